//--- hw/tdm_defines.svh
// address map, field layout and timing constants for the table/data block
`ifndef TDM_DEFINES_SVH
`define TDM_DEFINES_SVH

// special-function register addresses
`define ADDR_IND0 8'h00
`define ADDR_PTR0 8'h01
`define ADDR_IND1 8'h02
`define ADDR_PTR1 8'h03
`define ADDR_BANKPTR 8'h04
`define ADDR_TPTR_LO 8'h07
`define ADDR_THI_LATCH 8'h08
`define ADDR_TPTR_HI 8'h09
`define ADDR_EEPROM_CTL 8'h40

// general purpose area, same offsets in each bank
`define GP_BASE 8'h80
`define GP_LIMIT 8'hbf
`define GP_IDX_W 6
`define RAM_AW 7

// one bit per special-function address that is not implemented
`define SFR_UNUSED_MAP 128'hffffff60_00002001_e0004030_20000000

// field layout
`define BANK_BIT 0
`define TPTR_HI_W 3
`define LAST_PAGE 3'h7
`define THI_USED_MASK 8'hff
`define PM_AW 11

// timing: four clocks form one instruction cycle
`define INSTR_CLKS 4
`define TBL_INSTR_CYCLES 2
`define TBL_CLKS (`TBL_INSTR_CYCLES * `INSTR_CLKS)
`define TBL_CNT_W 3
`define ZERO_BYTE 8'h00

`endif

//--- hw/tdm_pkg.sv
// types shared by the table read and data memory access logic
package tdm_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {SEL_ZERO, SEL_OWN, SEL_RAM, SEL_EXT} rsel_t;
    typedef enum logic [1:0] {TBL_IDLE, TBL_ISSUE, TBL_CAPTURE, TBL_HOLD}
        tbl_state_t;
endpackage

//--- hw/gp_ram.sv
// general purpose data memory array, both banks, synchronous read
`timescale 1ns/100ps
`include "tdm_defines.svh"
module gp_ram #(
    parameter int W = 8,
    parameter int AW = `RAM_AW
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [0:(1<<AW)-1];

    // read-before-write: a read in the write cycle sees the old byte
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

//--- hw/table_read_and_data_memory_access.sv
// table read address forming and banked data memory access for the core
`timescale 1ns/100ps
`include "tdm_defines.svh"
module table_read_and_data_memory_access (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] DM_ADDR,
    input wire logic DM_RD,
    input wire logic DM_WR,
    input wire logic [7:0] DM_WDATA,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    input wire logic TBL_REQ,
    input wire logic TBL_LAST,
    input wire logic [7:0] TBL_DEST,
    output logic [10:0] PM_ADDR,
    output logic PM_RD,
    input wire logic [15:0] PM_DATA,
    output logic TBL_BUSY,
    output logic TBL_DONE,
    output logic [7:0] EXT_ADDR,
    output logic EXT_BANK,
    output logic EXT_RD,
    output logic EXT_WR,
    output logic [7:0] EXT_WDATA,
    input wire logic [7:0] EXT_RDATA
);
    // pointer and table registers
    tdm_pkg::byte_t mp0_q, mp1_q, tplo_q, thi_q, dest_q;
    logic bp_q;
    logic [`TPTR_HI_W-1:0] tphi_q;

    // table sequencer
    tdm_pkg::tbl_state_t state_q, state_d;
    logic [`TBL_CNT_W-1:0] cnt_q, cnt_d;
    logic busy_q, done_q, pm_rd_q;
    logic [`PM_AW-1:0] pm_addr_q;

    // read pipeline and outward strobes
    logic rd1_q, rd_valid_q;
    tdm_pkg::rsel_t rsel_q;
    tdm_pkg::byte_t own_q, rd_data_q, ext_addr_q, ext_wdata_q;
    logic ext_bank_q, ext_rd_q, ext_wr_q;

    // access source: the table write-back owns the port in its cycle
    logic tbl_wb, tbl_accept, acc_wr, acc_rd;
    tdm_pkg::byte_t acc_addr, acc_wdata;
    assign tbl_wb = (state_q == tdm_pkg::TBL_CAPTURE);
    assign tbl_accept = TBL_REQ & ~busy_q;
    assign acc_addr = tbl_wb ? dest_q : DM_ADDR;
    assign acc_wdata = tbl_wb ? PM_DATA[7:0] : DM_WDATA;
    assign acc_wr = tbl_wb | (DM_WR & ~busy_q);
    assign acc_rd = DM_RD & ~busy_q;

    // indirect redirection and bank choice
    logic via0, via1, self_ind, eff_bank;
    tdm_pkg::byte_t eff;
    assign via0 = (acc_addr == `ADDR_IND0);
    assign via1 = (acc_addr == `ADDR_IND1);
    assign eff = via0 ? mp0_q : (via1 ? mp1_q : acc_addr);
    // direct and first pair stay in bank 0, and
    assign eff_bank = via1 & bp_q;
    assign self_ind = (via0 | via1) &
        ((eff == `ADDR_IND0) | (eff == `ADDR_IND1));

    // address decode; special registers sit from zero upward
    logic in_sfr, in_gp, is_eec, unused_sfr, is_own;
    logic [127:0] unused_map;
    tdm_pkg::rsel_t sel;
    assign in_sfr = ~eff[7];
    assign in_gp = (eff >= `GP_BASE) & (eff <= `GP_LIMIT);
    assign is_eec = (eff == `ADDR_EEPROM_CTL) & eff_bank;
    assign unused_map = `SFR_UNUSED_MAP; // a bare literal cannot be indexed
    assign unused_sfr = in_sfr & unused_map[eff[6:0]] & ~is_eec;
    assign is_own = (eff == `ADDR_PTR0) | (eff == `ADDR_PTR1) |
        (eff == `ADDR_BANKPTR) | (eff == `ADDR_TPTR_LO) |
        (eff == `ADDR_THI_LATCH) | (eff == `ADDR_TPTR_HI);
    // holes and self-pointing read as zero
    assign sel = (self_ind | unused_sfr | (~in_sfr & ~in_gp)) ?
        tdm_pkg::SEL_ZERO : (in_gp ? tdm_pkg::SEL_RAM :
        (is_own ? tdm_pkg::SEL_OWN : tdm_pkg::SEL_EXT));

    // per-register write strobes; the latch has none
    logic wr_own, wr_mp0, wr_mp1, wr_bp, wr_tplo, wr_tphi, wr_ram;
    assign wr_own = acc_wr & (sel == tdm_pkg::SEL_OWN);
    assign wr_mp0 = wr_own & (eff == `ADDR_PTR0);
    assign wr_mp1 = wr_own & (eff == `ADDR_PTR1);
    assign wr_bp = wr_own & (eff == `ADDR_BANKPTR);
    assign wr_tplo = wr_own & (eff == `ADDR_TPTR_LO);
    assign wr_tphi = wr_own & (eff == `ADDR_TPTR_HI);
    assign wr_ram = acc_wr & (sel == tdm_pkg::SEL_RAM);

    // own register read value; unimplemented bits read zero
    tdm_pkg::byte_t own_val;
    assign own_val =
        (eff == `ADDR_PTR0) ? mp0_q :
        (eff == `ADDR_PTR1) ? mp1_q :
        (eff == `ADDR_BANKPTR) ? {7'h00, bp_q} :
        (eff == `ADDR_TPTR_LO) ? tplo_q :
        (eff == `ADDR_THI_LATCH) ? thi_q :
        {{(8-`TPTR_HI_W){1'b0}}, tphi_q};

    // table address: last page forces the top bits
    logic [`PM_AW-1:0] tbl_addr;
    assign tbl_addr = {(TBL_LAST ? `LAST_PAGE : tphi_q), tplo_q};

    // pointer registers; bank 0 after reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            mp0_q <= 8'h00;
            mp1_q <= 8'h00;
            bp_q <= 1'b0;
            tplo_q <= 8'h00;
            tphi_q <= 3'h0;
        end else begin
            if (wr_mp0) mp0_q <= acc_wdata;
            if (wr_mp1) mp1_q <= acc_wdata;
            if (wr_bp) bp_q <= acc_wdata[`BANK_BIT];
            if (wr_tplo) tplo_q <= acc_wdata;
            if (wr_tphi) tphi_q <= acc_wdata[`TPTR_HI_W-1:0];
        end
    end

    // high byte latch, loaded only by a table fetch
    always_ff @(posedge CLK) begin
        if (RST) begin
            thi_q <= 8'h00;
        end else if (tbl_wb) begin
            thi_q <= PM_DATA[15:8] & `THI_USED_MASK;
        end
    end

    // table sequencer: issue, capture, then hold out the second cycle
    always_comb begin
        state_d = state_q;
        cnt_d = (cnt_q == 3'h0) ? cnt_q : cnt_q - 3'h1;
        case (state_q)
            tdm_pkg::TBL_IDLE: begin
                if (tbl_accept) begin
                    state_d = tdm_pkg::TBL_ISSUE;
                    cnt_d = `TBL_CNT_W'(`TBL_CLKS - 1);
                end
            end
            tdm_pkg::TBL_ISSUE: state_d = tdm_pkg::TBL_CAPTURE;
            tdm_pkg::TBL_CAPTURE: state_d = tdm_pkg::TBL_HOLD;
            tdm_pkg::TBL_HOLD: begin
                if (cnt_q == 3'h0) state_d = tdm_pkg::TBL_IDLE;
            end
            default: state_d = tdm_pkg::TBL_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= tdm_pkg::TBL_IDLE;
            cnt_q <= 3'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            busy_q <= (state_d != tdm_pkg::TBL_IDLE);
            done_q <= (state_q == tdm_pkg::TBL_HOLD) & (cnt_q == 3'h1);
        end
    end

    // program memory request, one pulse per table read
    always_ff @(posedge CLK) begin
        if (RST) begin
            pm_rd_q <= 1'b0;
            pm_addr_q <= 11'h000;
            dest_q <= 8'h00;
        end else begin
            pm_rd_q <= tbl_accept;
            if (tbl_accept) begin
                pm_addr_q <= tbl_addr;
                dest_q <= TBL_DEST;
            end
        end
    end

    // general purpose storage; bank bit on top of the offset
    tdm_pkg::byte_t ram_rdata;
    gp_ram #(.W(8), .AW(`RAM_AW)) u_ram (
        .clk(CLK),
        .we(wr_ram),
        .addr({eff_bank, eff[`GP_IDX_W-1:0]}),
        .wdata(acc_wdata),
        .rdata(ram_rdata)
    );

    // outward strobes for registers kept elsewhere in the core
    always_ff @(posedge CLK) begin
        if (RST) begin
            ext_rd_q <= 1'b0;
            ext_wr_q <= 1'b0;
            ext_addr_q <= 8'h00;
            ext_bank_q <= 1'b0;
            ext_wdata_q <= 8'h00;
        end else begin
            ext_rd_q <= acc_rd & (sel == tdm_pkg::SEL_EXT);
            ext_wr_q <= acc_wr & (sel == tdm_pkg::SEL_EXT);
            ext_addr_q <= eff;
            ext_bank_q <= eff_bank;
            ext_wdata_q <= acc_wdata;
        end
    end

    // two-stage read: decode, then pick the source once ram has answered
    tdm_pkg::byte_t rd_mux;
    assign rd_mux =
        (rsel_q == tdm_pkg::SEL_OWN) ? own_q :
        (rsel_q == tdm_pkg::SEL_RAM) ? ram_rdata :
        (rsel_q == tdm_pkg::SEL_EXT) ? EXT_RDATA : `ZERO_BYTE;

    always_ff @(posedge CLK) begin
        if (RST) begin
            rd1_q <= 1'b0;
            rsel_q <= tdm_pkg::SEL_ZERO;
            own_q <= 8'h00;
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            rd1_q <= acc_rd;
            rsel_q <= sel;
            own_q <= own_val;
            rd_valid_q <= rd1_q;
            if (rd1_q) rd_data_q <= rd_mux;
        end
    end

    assign RD_DATA = rd_data_q;
    assign RD_VALID = rd_valid_q;
    assign PM_ADDR = pm_addr_q;
    assign PM_RD = pm_rd_q;
    assign TBL_BUSY = busy_q;
    assign TBL_DONE = done_q;
    assign EXT_ADDR = ext_addr_q;
    assign EXT_BANK = ext_bank_q;
    assign EXT_RD = ext_rd_q;
    assign EXT_WR = ext_wr_q;
    assign EXT_WDATA = ext_wdata_q;

    // checks on the table path and the address map
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_busy_span;
        TBL_BUSY [*8] ##1 !TBL_BUSY;
    endsequence

    sequence s_done_late;
        !TBL_DONE [*7] ##1 TBL_DONE;
    endsequence

    normal_addr_a: assert property (
        tbl_accept && !TBL_LAST |=>
            PM_ADDR == {$past(tphi_q), $past(tplo_q)} && PM_RD)
        else $error("normal table address not from both pointers");

    last_page_a: assert property (
        tbl_accept && TBL_LAST |=>
            PM_ADDR[10:8] == 3'h7 && PM_ADDR[7:0] == $past(tplo_q))
        else $error("last page table address wrong");

    latch_load_a: assert property (
        tbl_wb |=> thi_q == $past(PM_DATA[15:8]))
        else $error("high byte latch not loaded by fetch");

    latch_ro_a: assert property (
        acc_wr && !tbl_wb && eff == 8'h08 |=> $stable(thi_q))
        else $error("high byte latch changed by a write");

    table_span_a: assert property (
        tbl_accept |=> s_busy_span)
        else $error("table busy span not eight clocks");

    table_done_a: assert property (
        tbl_accept |=> s_done_late)
        else $error("table done not on eighth clock");

    low_byte_a: assert property (
        tbl_wb && dest_q == 8'h07 |=> tplo_q == $past(PM_DATA[7:0]))
        else $error("table low byte not written to operand");

    direct_bank_a: assert property (
        (acc_rd || acc_wr) && !via1 |-> !eff_bank)
        else $error("direct or first pair access left bank 0");

    second_pair_a: assert property (
        (acc_rd || acc_wr) && via1 |-> eff_bank == bp_q)
        else $error("second pair ignores bank pointer");

    ind_write_a: assert property (
        acc_wr && !tbl_wb && via0 && mp0_q == 8'h07 |=>
            tplo_q == $past(DM_WDATA))
        else $error("indirect write missed pointed register");

    self_zero_a: assert property (
        acc_rd && self_ind |=> ##1 RD_VALID && RD_DATA == 8'h00)
        else $error("self pointing read not zero");

    eeprom_bank_a: assert property (
        acc_rd && eff == 8'h40 && !eff_bank |=> !EXT_RD ##1 RD_DATA == 8'h00)
        else $error("eeprom control seen from bank 0");

    hole_zero_a: assert property (
        acc_wr && unused_sfr |=> !EXT_WR)
        else $error("write to unused address escaped");
endmodule

//--- tb/far_side_model.sv
// program memory and outside register model facing the block
`timescale 1ns/100ps
module far_side_model (
    input wire logic CLK,
    input wire logic [10:0] PM_ADDR,
    input wire logic PM_RD,
    output logic [15:0] PM_DATA,
    input wire logic [7:0] EXT_ADDR,
    input wire logic EXT_BANK,
    input wire logic EXT_RD,
    input wire logic EXT_WR,
    input wire logic [7:0] EXT_WDATA,
    output logic [7:0] EXT_RDATA
);
    logic [7:0] regs_q [0:511];
    logic [7:0] last_q;
    logic [8:0] idx;
    // only eeprom control at 40h is banked; other registers show in both
    assign idx = {EXT_BANK & (EXT_ADDR == 8'h40), EXT_ADDR};
    initial begin
        PM_DATA = 16'h0000;
        last_q = 8'h00;
        for (int i = 0; i < 512; i++) begin
            regs_q[i] = 8'h00;
        end
    end
    // word is good only in the cycle after the fetch, it toggles otherwise
    always @(posedge CLK) begin
        if (PM_RD) begin
            PM_DATA <= {PM_ADDR[7:0] ^ 8'ha5, PM_ADDR[10:3] ^ 8'h3c};
        end else begin
            PM_DATA <= ~PM_DATA;
        end
        // 40h does not exist in bank 0, so a wrong bank loses the write
        if (EXT_WR && (EXT_BANK || EXT_ADDR != 8'h40)) begin
            regs_q[idx] <= EXT_WDATA;
        end
        if (EXT_RD) begin
            last_q <= EXT_RDATA;
        end
    end
    // released bus shows the inverse of the last byte read
    assign EXT_RDATA = EXT_RD ? regs_q[idx] : ~last_q;
endmodule

//--- tb/tb.sv
// self-checking bench for the table read and data memory block
`timescale 1ns/100ps
module tb;
    logic CLK, RST, DM_RD, DM_WR, TBL_REQ, TBL_LAST;
    logic [7:0] DM_ADDR, DM_WDATA, TBL_DEST, RD_DATA;
    logic [7:0] EXT_ADDR, EXT_WDATA, EXT_RDATA;
    logic RD_VALID, PM_RD, TBL_BUSY, TBL_DONE, EXT_BANK, EXT_RD, EXT_WR;
    logic [10:0] PM_ADDR;
    logic [15:0] PM_DATA;
    logic [7:0] rd_exp_q [$];
    logic [10:0] pm_exp_q [$];
    logic [31:0] rng_q = 32'h00010b41;
    logic [7:0] b0, b1;
    logic [7:0] rst_list [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07,
        8'h08, 8'h09};
    logic [7:0] unused_list [4] = '{8'h1d, 8'hc0, 8'h40, 8'h3d};
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int busy_cnt = 0;

    table_read_and_data_memory_access dut (.CLK(CLK), .RST(RST),
        .DM_ADDR(DM_ADDR), .DM_RD(DM_RD), .DM_WR(DM_WR),
        .DM_WDATA(DM_WDATA), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
        .TBL_REQ(TBL_REQ), .TBL_LAST(TBL_LAST), .TBL_DEST(TBL_DEST),
        .PM_ADDR(PM_ADDR), .PM_RD(PM_RD), .PM_DATA(PM_DATA),
        .TBL_BUSY(TBL_BUSY), .TBL_DONE(TBL_DONE), .EXT_ADDR(EXT_ADDR),
        .EXT_BANK(EXT_BANK), .EXT_RD(EXT_RD), .EXT_WR(EXT_WR),
        .EXT_WDATA(EXT_WDATA), .EXT_RDATA(EXT_RDATA));
    far_side_model far (.CLK(CLK), .PM_ADDR(PM_ADDR), .PM_RD(PM_RD),
        .PM_DATA(PM_DATA), .EXT_ADDR(EXT_ADDR), .EXT_BANK(EXT_BANK),
        .EXT_RD(EXT_RD), .EXT_WR(EXT_WR), .EXT_WDATA(EXT_WDATA),
        .EXT_RDATA(EXT_RDATA));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
        input string what);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: %s seen %h expected %h", $time,
                what, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // our own picture of the program memory contents
    function automatic logic [15:0] pm_word(input logic [10:0] a);
        return {a[7:0] ^ 8'ha5, a[10:3] ^ 8'h3c};
    endfunction

    // one request then one idle edge, so no strobe is set twice at an edge
    task automatic dm_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        DM_WR <= 1'b1;
        DM_ADDR <= a;
        DM_WDATA <= d;
        @(posedge CLK);
        DM_WR <= 1'b0;
    endtask

    task automatic dm_read(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK);
        DM_RD <= 1'b1;
        DM_ADDR <= a;
        rd_exp_q.push_back(e);
        @(posedge CLK);
        DM_RD <= 1'b0;
    endtask

    task automatic tbl_read(input logic last, input logic [7:0] lo,
        input logic [2:0] hi, input logic [7:0] dest);
        logic [10:0] a;
        logic [15:0] w;
        a = {last ? 3'h7 : hi, lo};
        w = pm_word(a);
        dm_write(8'h07, lo);
        dm_write(8'h09, {5'h00, hi});
        pm_exp_q.push_back(a);
        @(posedge CLK);
        TBL_REQ <= 1'b1;
        TBL_LAST <= last;
        TBL_DEST <= dest;
        @(posedge CLK);
        TBL_REQ <= 1'b0;
        @(posedge CLK);
        // poke in the write-back cycle while busy: must be dropped
        DM_WR <= 1'b1;
        DM_ADDR <= dest;
        DM_WDATA <= ~w[7:0];
        @(posedge CLK);
        DM_WR <= 1'b0;
        while (TBL_BUSY !== 1'b0) @(posedge CLK);
        dm_read(dest, w[7:0]);
        dm_write(8'h08, ~w[15:8]);
        dm_read(8'h08, w[15:8]);
    endtask

    // results are matched against the oldest note as they appear
    always @(posedge CLK) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            test_done();
        end
        if (RD_VALID === 1'b1) begin
            if (rd_exp_q.size() > 0) begin
                check(RD_DATA, rd_exp_q.pop_front(),
                    "read data");
            end else begin
                check(1'b1, 1'b0, "stray read result");
            end
        end
        if (PM_RD === 1'b1) begin
            check(PM_ADDR, pm_exp_q.pop_front(),
                "fetch address");
        end
        if (TBL_BUSY === 1'b1) begin
            busy_cnt++;
        end
        if (TBL_DONE === 1'b1) begin
            check(16'(busy_cnt), 16'h0008, "table op length");
            busy_cnt = 0;
        end
    end

    initial begin
        RST = 1'b1;
        DM_RD = 1'b0;
        DM_WR = 1'b0;
        DM_ADDR = 8'h00;
        DM_WDATA = 8'h00;
        TBL_REQ = 1'b0;
        TBL_LAST = 1'b0;
        TBL_DEST = 8'h00;
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        // pointers and latch clear, indirect with null pointer reads zero
        foreach (rst_list[i]) dm_read(rst_list[i], 8'h00);
        $display("test reset values done");
        rng_q = next_rand(rng_q);
        b0 = rng_q[7:0];
        b1 = rng_q[15:8];
        dm_write(8'h80, b0);
        dm_write(8'hbf, b1);
        dm_read(8'h80, b0);
        dm_read(8'hbf, b1);
        foreach (unused_list[i]) begin
            dm_write(unused_list[i], 8'h5a);
            dm_read(unused_list[i], 8'h00);
        end
        $display("test general and unused area done");
        dm_write(8'h04, 8'hff);
        dm_read(8'h04, 8'h01);
        dm_write(8'h03, 8'h80);
        dm_write(8'h02, ~b0);
        dm_read(8'h80, b0);
        dm_read(8'h02, ~b0);
        dm_write(8'h01, 8'h80);
        dm_read(8'h00, b0);
        dm_write(8'h01, 8'h07);
        dm_write(8'h00, b1);
        dm_read(8'h07, b1);
        dm_write(8'h04, 8'h00);
        dm_read(8'h02, b0);
        $display("test banks and pointers done");
        dm_write(8'h0a, b1);
        dm_read(8'h0a, b1);
        dm_write(8'h03, 8'h40);
        dm_write(8'h02, 8'h77);
        dm_read(8'h02, 8'h00);
        dm_write(8'h04, 8'h01);
        dm_write(8'h02, 8'hc3);
        dm_read(8'h02, 8'hc3);
        dm_write(8'h03, 8'h02);
        dm_write(8'h02, 8'h55);
        dm_read(8'h02, 8'h00);
        dm_read(8'h03, 8'h02);
        // bank pointer still 1: an outside register must show in bank 1 too
        dm_write(8'h03, 8'h0a);
        dm_read(8'h02, b1);
        $display("test outside registers done");
        for (int i = 0; i < 6; i++) begin
            rng_q = next_rand(rng_q);
            tbl_read(i[0], rng_q[7:0], rng_q[10:8], {2'b10, rng_q[21:16]});
        end
        // operand is the low table pointer itself
        tbl_read(1'b0, 8'h3c, 3'h5, 8'h07);
        $display("test table reads done");
        repeat (4) @(posedge CLK);
        check(16'(rd_exp_q.size()), 16'h0000,
            "reads left unanswered");
        check(16'(pm_exp_q.size()), 16'h0000,
            "fetches never seen");
        test_done();
    end
endmodule
